// *** design/tmra_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the 16-bit timer.
// Assumes inclusion by the package and design files; definitions only.
// What this block does
// - One 16-bit counter counts in synchronous internal, internal gated, synchronous external or asynchronous external mode.
// - Control bit 15 runs the timer when one and stops it when zero.
// - Control bit 13 halts the timer in Idle when one, and lets it run in Idle when zero.
// - Control bit 12 drops count writes while an asynchronous write is pending, else writes go back to back.
// - Control bit 11 reads one while an asynchronous count write is in progress and always zero in synchronous mode.
// - Control bit 7 enables gated counting with the internal source and does nothing with the external source.
// - Control bits 5 to 4 divide the counting clock by 1, 8, 64 or 256.
// - Control bit 2 synchronises the external clock when one and bypasses the synchroniser when zero, external source only.
// - Control bit 1 selects the external clock pin when one and the internal clock when zero.
// - Unimplemented control bits read zero and all implemented control bits reset to zero.
// - The timer keeps working in Idle while control bit 13 is zero, and in Sleep only in asynchronous external mode.
// - The control, count and period registers have clear, set and invert aliases acting only on bits written as one.
`ifndef TMRA_DEFINES_SVH
`define TMRA_DEFINES_SVH

`define TMRA_OFF_CTRL    12'h000
`define TMRA_OFF_COUNT   12'h010
`define TMRA_OFF_PERIOD  12'h020
`define TMRA_OFF_STATUS  12'h030
`define TMRA_ALIAS_CLR   2'h1
`define TMRA_ALIAS_SET   2'h2
`define TMRA_ALIAS_INV   2'h3

`define TMRA_BIT_ON      15
`define TMRA_BIT_IDLE_STOP 13
`define TMRA_BIT_WDIS    12
`define TMRA_BIT_WIP     11
`define TMRA_BIT_GATE    7
`define TMRA_BIT_PS_HI   5
`define TMRA_BIT_PS_LO   4
`define TMRA_BIT_SYNC    2
`define TMRA_BIT_CS      1
`define TMRA_CTRL_WMASK  32'h0000_b0b6

`define TMRA_CTRL_RST    32'h0000_0000
`define TMRA_COUNT_RST   16'h0000
`define TMRA_PERIOD_RST  16'hffff

`define TMRA_PS_DIV1     8'h00
`define TMRA_PS_DIV8     8'h07
`define TMRA_PS_DIV64    8'h3f
`define TMRA_PS_DIV256   8'hff
`define TMRA_AWRITE_CYC  3'h3

`endif

// *** design/tmra_pkg.sv ***
// Types shared by the 16-bit timer design files.
// Assumes the defines header sits beside it.
`include "tmra_defines.svh"
package tmra_pkg;
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hsel;
        logic        hready;
    } tmra_ahb_req_t;

    typedef struct packed {
        logic        run_en;
        logic        idle_stop;
        logic        async_write_block;
        logic        gate_accumulate_en;
        logic [1:0]  prescale_select;
        logic        ext_clock_sync_en;
        logic        clock_source_select;
    } tmra_ctrl_t;

    typedef enum logic [2:0] {
        TMRA_W_IDLE = 3'b001,
        TMRA_W_BUSY = 3'b010,
        TMRA_W_DONE = 3'b100
    } tmra_wstate_t;
endpackage : tmra_pkg

// *** design/tmra_edge.sv ***
// Rising and falling edge detector with an optional two-stage synchroniser.
// Assumes a single clock; the raw path is for inputs already in this domain.
`timescale 1ns/1ns
module tmra_edge (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic sig_in,
    input  wire logic sync_en_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    import tmra_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic last;
    } tmra_edge_st_t;
    tmra_edge_st_t st_q;
    tmra_edge_st_t st_d;
    logic          cur;

    always_comb begin
        st_d      = st_q;
        st_d.s1   = sig_in;
        st_d.s2   = st_q.s1;
        cur       = sync_en_in ? st_q.s2 : sig_in;
        st_d.last = cur;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = cur;
    assign rise_out  = cur & ~st_q.last;
    assign fall_out  = ~cur & st_q.last;
endmodule : tmra_edge

// *** design/tmra_prescaler.sv ***
// Prescaler: one tick out per 1, 8, 64 or 256 input events.
// Assumes events are one-cycle pulses in the single clock domain.
`timescale 1ns/1ns
`include "tmra_defines.svh"
module tmra_prescaler (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       clear_in,
    input  wire logic [1:0] select_in,
    input  wire logic       event_in,
    output logic            tick_out
);
    import tmra_pkg::*;
    typedef struct packed {
        logic [7:0] cnt;
    } tmra_ps_st_t;
    tmra_ps_st_t st_q;
    tmra_ps_st_t st_d;
    logic [7:0]  limit;

    always_comb begin
        case (select_in)
            2'h0:    limit = `TMRA_PS_DIV1;
            2'h1:    limit = `TMRA_PS_DIV8;
            2'h2:    limit = `TMRA_PS_DIV64;
            default: limit = `TMRA_PS_DIV256;
        endcase
        st_d     = st_q;
        tick_out = 1'b0;
        if (clear_in) begin
            st_d.cnt = 8'h00;
        end else if (event_in) begin
            if (st_q.cnt >= limit) begin
                st_d.cnt = 8'h00;
                tick_out = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    div1_tick_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (select_in == 2'h0 && event_in && !clear_in) |-> tick_out)
        else $error("Divide by one missed a tick");
endmodule : tmra_prescaler

// *** design/tmra_timer.sv ***
// 16-bit type A timer with control, count, period and status registers on AHB-Lite.
// Assumes a single 100 MHz clock; external pin, gate and power-mode levels arrive synchronous to it.
`timescale 1ns/1ns
`include "tmra_defines.svh"
module tmra_timer (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        ext_clock_pin_in,
    input  wire logic        gate_in,
    input  wire logic        idle_mode_in,
    input  wire logic        sleep_mode_in,
    output logic             period_flag_out,
    output logic [15:0]      count_out
);
    import tmra_pkg::*;

    typedef struct packed {
        tmra_ahb_req_t ap;
        tmra_ctrl_t    ctrl;
        logic [15:0]   count;
        logic [15:0]   period;
        logic [15:0]   wdata;
        tmra_wstate_t  wst;
        logic [2:0]    wcnt;
        logic          flag;
        logic          flag_out;
        logic [31:0]   rdata;
    } tmra_st_t;

    tmra_st_t    st_q;
    tmra_st_t    st_d;
    logic        wr_phase;
    logic        rd_now;
    logic [11:0] off;
    logic [1:0]  alias_sel;
    logic [31:0] ctrl_word;
    logic        async_mode;
    logic        ext_lvl;
    logic        ext_rise;
    logic        gate_lvl;
    logic        gate_fall;
    logic        src_event;
    logic        tick;
    logic        halted;
    logic        count_wr;
    logic [31:0] new_val;
    logic [31:0] cur_val;

    // Register word assembly; unimplemented bits stay zero
    always_comb begin
        ctrl_word                  = `TMRA_CTRL_RST;
        ctrl_word[`TMRA_BIT_ON]    = st_q.ctrl.run_en;
        ctrl_word[`TMRA_BIT_IDLE_STOP] = st_q.ctrl.idle_stop;
        ctrl_word[`TMRA_BIT_WDIS]  = st_q.ctrl.async_write_block;
        ctrl_word[`TMRA_BIT_WIP]   = async_mode && (st_q.wst != TMRA_W_IDLE);
        ctrl_word[`TMRA_BIT_GATE]  = st_q.ctrl.gate_accumulate_en;
        ctrl_word[`TMRA_BIT_PS_HI:`TMRA_BIT_PS_LO] = st_q.ctrl.prescale_select;
        ctrl_word[`TMRA_BIT_SYNC]  = st_q.ctrl.ext_clock_sync_en;
        ctrl_word[`TMRA_BIT_CS]    = st_q.ctrl.clock_source_select;
    end

    // Asynchronous mode: external source with synchroniser bypassed
    assign async_mode = st_q.ctrl.clock_source_select & ~st_q.ctrl.ext_clock_sync_en;

    tmra_edge u_ext_edge (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .sig_in     (ext_clock_pin_in),
        .sync_en_in (st_q.ctrl.ext_clock_sync_en),
        .level_out  (ext_lvl),
        .rise_out   (ext_rise),
        .fall_out   ()
    );

    tmra_edge u_gate_edge (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .sig_in     (gate_in),
        .sync_en_in (1'b0),
        .level_out  (gate_lvl),
        .rise_out   (),
        .fall_out   (gate_fall)
    );

    // Idle stop; sleep stops internal and synchronised external counting, async pin counting goes on
    always_comb begin
        halted = ~st_q.ctrl.run_en;
        if (idle_mode_in && st_q.ctrl.idle_stop) begin
            halted = 1'b1;
        end
        if (sleep_mode_in && !async_mode) begin
            halted = 1'b1;
        end
    end

    // Source selection
    always_comb begin
        if (st_q.ctrl.clock_source_select) begin
            src_event = ext_rise;
        end else if (st_q.ctrl.gate_accumulate_en) begin
            src_event = gate_lvl;
        end else begin
            src_event = 1'b1;
        end
        src_event = src_event & ~halted;
    end

    tmra_prescaler u_ps (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .clear_in  (~st_q.ctrl.run_en),
        .select_in (st_q.ctrl.prescale_select),
        .event_in  (src_event),
        .tick_out  (tick)
    );

    assign wr_phase  = st_q.ap.hsel & st_q.ap.htrans[1] & st_q.ap.hwrite;
    assign off       = {st_q.ap.haddr[11:4], 4'h0};
    assign alias_sel = st_q.ap.haddr[3:2];
    assign rd_now    = hsel_in & hready_in & htrans_in[1] & ~hwrite_in;

    // Alias operation on the addressed register
    always_comb begin
        case (off)
            `TMRA_OFF_CTRL:   cur_val = ctrl_word;
            `TMRA_OFF_COUNT:  cur_val = {16'h0000, st_q.count};
            `TMRA_OFF_PERIOD: cur_val = {16'h0000, st_q.period};
            default:          cur_val = 32'h0000_0000;
        endcase
        case (alias_sel)
            `TMRA_ALIAS_CLR: new_val = cur_val & ~hwdata_in;
            `TMRA_ALIAS_SET: new_val = cur_val | hwdata_in;
            `TMRA_ALIAS_INV: new_val = cur_val ^ hwdata_in;
            default:         new_val = hwdata_in;
        endcase
    end

    // Count write dropped only when blocking and a write is still pending
    assign count_wr = wr_phase && (off == `TMRA_OFF_COUNT) &&
                      !(st_q.ctrl.async_write_block && st_q.wst != TMRA_W_IDLE);

    always_comb begin
        st_d = st_q;
        if (hready_in) begin
            st_d.ap = '{haddr: haddr_in, htrans: htrans_in, hwrite: hwrite_in,
                        hsize: hsize_in, hsel: hsel_in, hready: hready_in};
        end
        if (wr_phase && off == `TMRA_OFF_CTRL) begin
            st_d.ctrl.run_en              = new_val[`TMRA_BIT_ON];
            st_d.ctrl.idle_stop           = new_val[`TMRA_BIT_IDLE_STOP];
            st_d.ctrl.async_write_block   = new_val[`TMRA_BIT_WDIS];
            st_d.ctrl.gate_accumulate_en  = new_val[`TMRA_BIT_GATE];
            st_d.ctrl.prescale_select     = new_val[`TMRA_BIT_PS_HI:`TMRA_BIT_PS_LO];
            st_d.ctrl.ext_clock_sync_en   = new_val[`TMRA_BIT_SYNC];
            st_d.ctrl.clock_source_select = new_val[`TMRA_BIT_CS];
        end
        if (wr_phase && off == `TMRA_OFF_PERIOD) begin
            st_d.period = new_val[15:0];
        end
        if (wr_phase && off == `TMRA_OFF_STATUS && hwdata_in[0]) begin
            st_d.flag = 1'b0;
        end
        // Counting; match wraps to zero on the following tick
        if (tick) begin
            if (st_q.count == st_q.period) begin
                st_d.count = 16'h0000;
                st_d.flag  = 1'b1;
            end else begin
                st_d.count = st_q.count + 16'h0001;
            end
        end
        if (gate_fall && st_q.ctrl.gate_accumulate_en && !st_q.ctrl.clock_source_select && !halted) begin
            st_d.flag = 1'b1;
        end
        // Count writes: immediate in sync mode, delayed handoff in async mode
        case (st_q.wst)
            TMRA_W_IDLE: begin
                if (count_wr && async_mode) begin
                    st_d.wdata = new_val[15:0];
                    st_d.wcnt  = `TMRA_AWRITE_CYC;
                    st_d.wst   = TMRA_W_BUSY;
                end else if (count_wr) begin
                    st_d.count = new_val[15:0];
                end
            end
            TMRA_W_BUSY: begin
                if (count_wr) begin
                    st_d.wdata = new_val[15:0];
                    st_d.wcnt  = `TMRA_AWRITE_CYC;
                end else if (st_q.wcnt == 3'h1) begin
                    st_d.wst = TMRA_W_DONE;
                end else begin
                    st_d.wcnt = st_q.wcnt - 3'h1;
                end
            end
            TMRA_W_DONE: begin
                st_d.count = st_q.wdata;
                st_d.wst   = TMRA_W_IDLE;
                // A write arriving as the last one lands is taken unless control bit 12 blocks it
                if (count_wr && async_mode) begin
                    st_d.wdata = new_val[15:0];
                    st_d.wcnt  = `TMRA_AWRITE_CYC;
                    st_d.wst   = TMRA_W_BUSY;
                end else if (count_wr) begin
                    st_d.count = new_val[15:0];
                end
            end
            default: begin
                st_d.wst = TMRA_W_IDLE;
            end
        endcase
        if (!async_mode && st_q.wst == TMRA_W_BUSY && !count_wr) begin
            st_d.wst = TMRA_W_DONE;
        end
        st_d.flag_out = st_d.flag;
        if (rd_now) begin
            case ({haddr_in[11:4], 4'h0})
                `TMRA_OFF_CTRL:   st_d.rdata = ctrl_word;
                `TMRA_OFF_COUNT:  st_d.rdata = {16'h0000, st_q.count};
                `TMRA_OFF_PERIOD: st_d.rdata = {16'h0000, st_q.period};
                `TMRA_OFF_STATUS: st_d.rdata = {31'h0, st_q.flag};
                default:          st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q        <= '0;
            st_q.ctrl   <= '0;
            st_q.count  <= `TMRA_COUNT_RST;
            st_q.period <= `TMRA_PERIOD_RST;
            st_q.wst    <= TMRA_W_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign hrdata_out      = st_q.rdata;
    assign hreadyout_out   = 1'b1;
    assign hresp_out       = 1'b0;
    assign period_flag_out = st_q.flag_out;
    assign count_out       = st_q.count;

    stopped_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (!st_q.ctrl.run_en && st_q.wst == TMRA_W_IDLE && !wr_phase) |=> $stable(st_q.count))
        else $error("Count moved while timer off");
    off_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !st_q.ctrl.run_en |-> !tick)
        else $error("Tick while timer off");
    idle_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (idle_mode_in && st_q.ctrl.idle_stop) |-> !tick)
        else $error("Tick during idle stop");
    blocked_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q.ctrl.async_write_block && st_q.wst == TMRA_W_BUSY) |=> $stable(st_q.wdata))
        else $error("Blocked count write was taken");
    sync_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (count_wr && !async_mode && st_q.wst == TMRA_W_IDLE) |=> (st_q.count == $past(new_val[15:0])))
        else $error("Sync count write not applied");
    wip_sync_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !async_mode |-> !ctrl_word[`TMRA_BIT_WIP])
        else $error("Write pending shown in sync mode");
    async_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q.wst == TMRA_W_IDLE && count_wr && async_mode) |=> ctrl_word[`TMRA_BIT_WIP])
        else $error("Async write not marked pending");
    async_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q.wst == TMRA_W_DONE && !count_wr)
        |=> (st_q.count == $past(st_q.wdata) && !ctrl_word[`TMRA_BIT_WIP]))
        else $error("Async write did not complete");
    reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ctrl_word & ~(`TMRA_CTRL_WMASK | 32'h0000_0800)) == 32'h0)
        else $error("Reserved control bit set");
    wrap_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick && st_q.count == st_q.period && !count_wr && st_q.wst == TMRA_W_IDLE)
        |=> (st_q.count == 16'h0000 && st_q.flag))
        else $error("Period match did not wrap");
    gate_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q.ctrl.gate_accumulate_en && !st_q.ctrl.clock_source_select && !gate_lvl) |-> !tick)
        else $error("Gated count with gate low");
    gate_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (gate_fall && st_q.ctrl.gate_accumulate_en && !st_q.ctrl.clock_source_select && !halted) |=> st_q.flag)
        else $error("Gate fall did not set flag");
    ext_source_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q.ctrl.clock_source_select && !ext_rise) |-> !src_event)
        else $error("External mode counted without edge");
    sync_bypass_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q.ctrl.clock_source_select && !st_q.ctrl.ext_clock_sync_en) |-> (ext_lvl == ext_clock_pin_in))
        else $error("Unsynchronised pin path delayed");
    sync_delay_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q.ctrl.clock_source_select && st_q.ctrl.ext_clock_sync_en) |-> (ext_lvl == $past(ext_clock_pin_in, 2)))
        else $error("Synchronised pin path not two stages");
    sleep_async_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (sleep_mode_in && async_mode && st_q.ctrl.run_en && !(idle_mode_in && st_q.ctrl.idle_stop))
        |-> (src_event == ext_rise))
        else $error("Async counting stopped in sleep");
    set_alias_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_phase && off == `TMRA_OFF_PERIOD && alias_sel == `TMRA_ALIAS_SET)
        |=> ((st_q.period & $past(hwdata_in[15:0])) == $past(hwdata_in[15:0])))
        else $error("Set alias missed bits");
endmodule : tmra_timer

// *** verif/tmra_timer_test.sv ***
// Self-checking testbench for the 16-bit type A timer.
// Assumes the design files under design/ and a 100 MHz clock; one AHB-Lite master is modelled here.
`timescale 1ns/1ns
`include "tmra_defines.svh"
module tmra_timer_test;
    localparam logic [31:0] A_CTRL   = {20'h0, `TMRA_OFF_CTRL};
    localparam logic [31:0] A_COUNT  = {20'h0, `TMRA_OFF_COUNT};
    localparam logic [31:0] A_PERIOD = {20'h0, `TMRA_OFF_PERIOD};
    localparam logic [31:0] A_STATUS = {20'h0, `TMRA_OFF_STATUS};

    typedef struct packed {
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [31:0] raddr;
        logic [31:0] expect_val;
    } tmra_row_t;

    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        pin = 1'b0;
    logic        gate = 1'b0;
    logic        idle = 1'b0;
    logic        sleep = 1'b0;
    wire  [31:0] hrdata;
    wire         hready;
    wire         hresp;
    wire         flag;
    wire  [15:0] count_out;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [31:0] rd;
    logic [15:0] c0;
    logic [15:0] seen_count;
    logic        seen_flag;
    int          n;
    tmra_row_t   rows [10];
    int          divs [4] = '{1, 8, 64, 256};

    tmra_timer tmra_timer_inst (
        .clk_in           (clk_in),
        .rst_in           (rst_in),
        .hsel_in          (hsel),
        .haddr_in         (haddr),
        .htrans_in        (htrans),
        .hwrite_in        (hwrite),
        .hsize_in         (3'h2),
        .hwdata_in        (hwdata),
        .hready_in        (hready),
        .hrdata_out       (hrdata),
        .hreadyout_out    (hready),
        .hresp_out        (hresp),
        .ext_clock_pin_in (pin),
        .gate_in          (gate),
        .idle_mode_in     (idle),
        .sleep_mode_in    (sleep),
        .period_flag_out  (flag),
        .count_out        (count_out)
    );

    always #5 clk_in = ~clk_in;

    // Outputs taken mid-cycle, away from the edge that launches them
    always @(negedge clk_in) begin
        seen_count <= count_out;
        seen_flag  <= flag;
    end

    task automatic report_and_stop;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask : check_flag

    // Called just after a rising edge; returns on the edge that ends the data phase
    task automatic bus_op(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_in); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus_op

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_op(a, 1'b1, d, dummy);
    endtask : wr

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus_op(a, 1'b0, 32'h0, r);
        check_word(r, exp);
        check_flag(hresp, 1'b0);
    endtask : rdchk

    task automatic cycles(input int k);
        repeat (k) @(posedge clk_in);
    endtask : cycles

    // Stop, clear the count in synchronous mode, then apply the new control word
    task automatic restart(input logic [31:0] ctrl);
        wr(A_CTRL, 32'h0);
        cycles(1);
        wr(A_COUNT, 32'h0);
        wr(A_STATUS, 32'h1);
        wr(A_CTRL, ctrl);
    endtask : restart

    task automatic gap(output int k);
        logic [15:0] c;
        #1;
        c = count_out;
        k = 0;
        while (count_out === c && k < 600) begin
            @(posedge clk_in);
            #1;
            k++;
        end
    endtask : gap

    task automatic pulses(input int k);
        repeat (k) begin
            pin <= 1'b1;
            cycles(3);
            pin <= 1'b0;
            cycles(3);
        end
    endtask : pulses

    initial begin
        #300000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rows[0] = '{A_CTRL, 32'hffff_ffff, A_CTRL, 32'h0000_b0b6};
        rows[1] = '{A_CTRL + 32'h4, 32'h0000_8000, A_CTRL, 32'h0000_30b6};
        rows[2] = '{A_CTRL + 32'h8, 32'h0000_8000, A_CTRL, 32'h0000_b0b6};
        rows[3] = '{A_CTRL + 32'hc, 32'h0000_80b6, A_CTRL, 32'h0000_3000};
        rows[4] = '{A_CTRL, 32'h0, A_CTRL, 32'h0};
        rows[5] = '{A_PERIOD, 32'h0001_1234, A_PERIOD, 32'h0000_1234};
        rows[6] = '{A_PERIOD + 32'h8, 32'h1, A_PERIOD, 32'h0000_1235};
        rows[7] = '{A_PERIOD + 32'h4, 32'h1200, A_PERIOD, 32'h0000_0035};
        rows[8] = '{A_PERIOD + 32'hc, 32'hffff, A_PERIOD, 32'h0000_ffca};
        rows[9] = '{32'h0000_0040, 32'hffff, 32'h0000_0040, 32'h0};
        cycles(3);
        rst_in <= 1'b0;
        cycles(1);
        foreach (rows[i]) begin
            wr(rows[i].waddr, rows[i].wdata);
            rdchk(rows[i].raddr, rows[i].expect_val);
        end
        // Every prescale ratio, measured between two count steps
        wr(A_PERIOD, 32'hffff);
        for (int ps = 0; ps < 4; ps++) begin
            restart(32'h8000 | (ps << 4));
            gap(n);
            gap(n);
            check_word(n, divs[ps]);
            cycles(1);
        end
        restart(32'h0);
        #1;
        c0 = count_out;
        cycles(10);
        check_word(seen_count, c0);
        // Match with the period, wrap to zero, flag, clear
        wr(A_PERIOD, 32'h3);
        restart(32'h8000);
        n = 0;
        while (count_out !== 16'h3 && n < 20) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        @(posedge clk_in);
        #1;
        check_word(count_out, 16'h0);
        cycles(1);
        check_flag(seen_flag, 1'b1);
        restart(32'h0);
        rdchk(A_STATUS, 32'h0);
        check_flag(seen_flag, 1'b0);
        wr(A_PERIOD, 32'hffff);
        // Gated accumulation
        restart(32'h8080);
        #1;
        c0 = count_out;
        cycles(10);
        check_word(seen_count, c0);
        gate <= 1'b1;
        cycles(10);
        check_flag(seen_count > c0, 1'b1);
        gate <= 1'b0;
        cycles(3);
        check_flag(seen_flag, 1'b1);
        restart(32'h8086);
        pulses(5);
        cycles(4);
        check_word(seen_count, 16'h5);
        // External clock, synchronised and not
        restart(32'h8006);
        pulses(6);
        cycles(4);
        check_word(seen_count, 16'h6);
        restart(32'h8002);
        pulses(6);
        cycles(4);
        check_word(seen_count, 16'h6);
        // Idle and Sleep behaviour
        idle <= 1'b1;
        restart(32'ha000);
        cycles(20);
        check_word(seen_count, 16'h0);
        restart(32'h8000);
        cycles(20);
        check_flag(seen_count > 16'h0, 1'b1);
        idle <= 1'b0;
        sleep <= 1'b1;
        restart(32'h8000);
        cycles(20);
        check_word(seen_count, 16'h0);
        restart(32'h8002);
        pulses(4);
        cycles(4);
        check_word(seen_count, 16'h4);
        sleep <= 1'b0;
        // Asynchronous count writes: pending bit and write blocking
        restart(32'h8002);
        wr(A_COUNT, 32'h55);
        rdchk(A_CTRL, 32'h0000_8802);
        cycles(10);
        rdchk(A_CTRL, 32'h0000_8002);
        check_word(seen_count, 16'h55);
        restart(32'h9002);
        wr(A_COUNT, 32'h11);
        wr(A_COUNT, 32'h22);
        cycles(10);
        check_word(seen_count, 16'h11);
        restart(32'h8002);
        wr(A_COUNT, 32'h33);
        wr(A_COUNT, 32'h44);
        cycles(10);
        check_word(seen_count, 16'h44);
        // Reset in mid-run restores every register
        wr(A_PERIOD, 32'h7);
        wr(A_CTRL, 32'h8000);
        rst_in <= 1'b1;
        cycles(3);
        rst_in <= 1'b0;
        check_word(seen_count, 16'h0);
        check_flag(seen_flag, 1'b0);
        rdchk(A_CTRL, 32'h0);
        rdchk(A_PERIOD, {16'h0, `TMRA_PERIOD_RST});
        rdchk(A_COUNT, 32'h0);
        rdchk(A_STATUS, 32'h0);
        report_and_stop();
    end
endmodule : tmra_timer_test
